// ==== src/converter_setting_regs.sv ====
// converter setting register slice: byte registers 5h-9h, decoded outputs,
// step-up enable selection and step-down A on/off delay sequencer
// assumes a serial-bus front end that issues one-cycle write strobes
// Contract
// - step-down B current limit bits 5-3, 1.5 A plus 0.5 A per code; 7 reserved.
// - limit code takes effect immediately, also while the converter runs.
// - ramp rate bits 2-0, codes 2..7 from 10 down to 0.47 mV/us.
// - setting fields load defaults from programmable memory after power-up.
// - voltage codes 14h-17h give 0.70-0.73 V in 10 mV steps.
// - voltage codes 18h-9Dh give 0.735-1.4 V in 5 mV steps.
// - voltage codes 9Eh-FFh give 1.42-3.36 V in 20 mV steps.
// - step-up voltage bits 7-6 give 4.9, 5.0, 5.1, 5.2 V.
// - step-up bit 3 connects discharge resistor while disabled; resets to 1.
// - step-up source bits 2-1: bit alone, or bit AND pin one/two/three.
// - step-up bit 0 enables the converter, gated by the selected source.
// - step-down A off delay bits 7-4, 0.5 ms per code after falling control.
// - delay-scale bit set doubles every step to 1 ms, 15 ms maximum.
// - step-down A on delay bits 3-0, same step scale after rising control.
`timescale 1ns/10ps
`default_nettype none
module converter_setting_regs #(
  parameter int STEP_CYC = csr_pkg::STEP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        regWrite,
  input  wire logic [3:0]  regAddr,
  input  wire logic [7:0]  regWdata,
  output logic      [7:0]  regRdata,
  input  wire logic        otpLoad,
  input  wire logic [7:0]  otpLimitSlew,
  input  wire logic [7:0]  otpVcodeA,
  input  wire logic [7:0]  otpVcodeB,
  input  wire logic [7:0]  otpStepup,
  input  wire logic [7:0]  otpSeqA,
  input  wire logic        enablePinFirst,
  input  wire logic        enablePinSecond,
  input  wire logic        enablePinThird,
  input  wire logic        delayScale,
  input  wire logic        stepdownACtrlBit,
  input  wire logic [1:0]  stepdownASrc,
  output logic      [2:0]  stepdownBPeakLimit,
  output logic      [12:0] stepdownBLimitMa,
  output logic      [2:0]  stepdownBRampRate,
  output logic      [7:0]  stepdownBRampCode,
  output logic      [11:0] stepdownAMv,
  output logic      [11:0] stepdownBMv,
  output logic      [1:0]  stepupVoltageCode,
  output logic      [12:0] stepupMv,
  output logic             stepupDischargeOn,
  output logic             stepupForcedFixedFreq,
  output logic             stepupRun,
  output logic             stepdownARun
);
  logic [7:0] limitSlew;
  logic [7:0] vcodeA;
  logic [7:0] vcodeB;
  logic [7:0] stepupCtl;
  logic [7:0] seqA;

  function automatic logic selEnable(input logic bitEn, input logic [1:0] src,
                                     input logic p1, input logic p2, input logic p3);
    unique case (src)
      csr_pkg::SRC_BIT_ONLY: selEnable = bitEn;
      csr_pkg::SRC_PIN_1:    selEnable = bitEn & p1;
      csr_pkg::SRC_PIN_2:    selEnable = bitEn & p2;
      default:               selEnable = bitEn & p3;
    endcase
  endfunction : selEnable

  // reserved codes 00h-13h map to the lowest level, the host must not use them
  function automatic logic [11:0] vcodeMv(input logic [7:0] c);
    logic [11:0] c12;
    c12 = {4'h0, c};
    if (c < csr_pkg::VCODE_10MV_LO) begin
      vcodeMv = csr_pkg::MV_BASE_10;
    end else if (c < csr_pkg::VCODE_5MV_LO) begin
      vcodeMv = 12'(csr_pkg::MV_BASE_10 + (c12 - 12'(csr_pkg::VCODE_10MV_LO)) * csr_pkg::MV_STEP_10);
    end else if (c < csr_pkg::VCODE_20MV_LO) begin
      vcodeMv = 12'(csr_pkg::MV_BASE_5 + (c12 - 12'(csr_pkg::VCODE_5MV_LO)) * csr_pkg::MV_STEP_5);
    end else begin
      vcodeMv = 12'(csr_pkg::MV_BASE_20 + (c12 - 12'(csr_pkg::VCODE_20MV_LO)) * csr_pkg::MV_STEP_20);
    end
  endfunction : vcodeMv

  // otp load comes after reset release; register writes lose to it in that cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limitSlew <= csr_pkg::RST_LIMIT_SLEW;
      vcodeA    <= csr_pkg::RST_VCODE;
      vcodeB    <= csr_pkg::RST_VCODE;
      stepupCtl <= csr_pkg::RST_STEPUP;
      seqA      <= csr_pkg::RST_SEQ;
    end else if (otpLoad) begin
      limitSlew <= otpLimitSlew;
      vcodeA    <= otpVcodeA;
      vcodeB    <= otpVcodeB;
      stepupCtl <= otpStepup;
      seqA      <= otpSeqA;
    end else if (regWrite) begin
      // no gating on converter state, limit changes land at once
      unique case (regAddr)
        csr_pkg::ADDR_LIMIT_SLEW: limitSlew <= regWdata;
        csr_pkg::ADDR_VCODE_A:    vcodeA <= regWdata;
        csr_pkg::ADDR_VCODE_B:    vcodeB <= regWdata;
        csr_pkg::ADDR_STEPUP:     stepupCtl <= regWdata;
        csr_pkg::ADDR_SEQ_A:      seqA <= regWdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (regAddr)
      csr_pkg::ADDR_LIMIT_SLEW: regRdata = limitSlew;
      csr_pkg::ADDR_VCODE_A:    regRdata = vcodeA;
      csr_pkg::ADDR_VCODE_B:    regRdata = vcodeB;
      csr_pkg::ADDR_STEPUP:     regRdata = stepupCtl;
      csr_pkg::ADDR_SEQ_A:      regRdata = seqA;
      default:                  regRdata = 8'h00;
    endcase
  end

  logic stepupSel;
  assign stepupSel = selEnable(stepupCtl[csr_pkg::SU_EN], stepupCtl[csr_pkg::SU_SRC_HI:csr_pkg::SU_SRC_LO],
                               enablePinFirst, enablePinSecond, enablePinThird);
  logic ctrlA;
  assign ctrlA = selEnable(stepdownACtrlBit, stepdownASrc,
                           enablePinFirst, enablePinSecond, enablePinThird);

  // decoded outputs registered; reserved codes decode like the rest (limit 7 to 5000 mA, ramp 0/1 to none, voltage 00h-13h to 700 mV)
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stepdownBPeakLimit    <= 3'h0;
      stepdownBLimitMa      <= 13'h0000;
      stepdownBRampRate     <= 3'h0;
      stepdownBRampCode     <= 8'h00;
      stepdownAMv           <= 12'h000;
      stepdownBMv           <= 12'h000;
      stepupVoltageCode     <= 2'h0;
      stepupMv              <= 13'h0000;
      stepupDischargeOn     <= 1'b0;
      stepupForcedFixedFreq <= 1'b0;
      stepupRun             <= 1'b0;
    end else begin
      stepdownBPeakLimit <= limitSlew[csr_pkg::LIM_HI:csr_pkg::LIM_LO];
      // 13 bits: 4.5 A and the reserved code's 5000 do not fit in 12
      stepdownBLimitMa   <= 13'(13'd1500 + 13'(limitSlew[csr_pkg::LIM_HI:csr_pkg::LIM_LO]) * 13'd500);
      stepdownBRampRate  <= limitSlew[csr_pkg::RAMP_HI:csr_pkg::RAMP_LO];
      // one-hot ramp select, bit n for code n; reserved 0/1 select nothing
      stepdownBRampCode  <= (limitSlew[csr_pkg::RAMP_HI:csr_pkg::RAMP_LO] > csr_pkg::RAMP_RSV_MAX) ?
                            8'(8'h01 << limitSlew[csr_pkg::RAMP_HI:csr_pkg::RAMP_LO]) : 8'h00;
      stepdownAMv        <= vcodeMv(vcodeA);
      stepdownBMv        <= vcodeMv(vcodeB);
      stepupVoltageCode  <= stepupCtl[csr_pkg::SU_V_HI:csr_pkg::SU_V_LO];
      stepupMv           <= 13'(13'd4900 + 13'(stepupCtl[csr_pkg::SU_V_HI:csr_pkg::SU_V_LO]) * 13'd100);
      stepupDischargeOn  <= stepupCtl[csr_pkg::SU_DIS] & ~stepupSel;
      stepupForcedFixedFreq <= 1'b0;
      stepupRun          <= stepupSel;
    end
  end

  // sequencer for step-down A
  csr_pkg::csr_seq_e seqState;
  logic [3:0]  stepsLeft;
  logic [19:0] cycCnt;
  logic        ctrlPrev;
  logic [19:0] stepLen;
  logic [3:0]  onCode;
  logic [3:0]  offCode;
  assign stepLen = delayScale ? 20'(2 * STEP_CYC) : 20'(STEP_CYC);
  assign onCode  = seqA[csr_pkg::ON_HI:csr_pkg::ON_LO];
  assign offCode = seqA[csr_pkg::OFF_HI:csr_pkg::OFF_LO];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlPrev <= 1'b0;
    end else begin
      ctrlPrev <= ctrlA;
    end
  end

  // a control edge during a running delay restarts the opposite delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seqState     <= csr_pkg::CSR_OFF;
      stepsLeft    <= 4'h0;
      cycCnt       <= 20'h00000;
      stepdownARun <= 1'b0;
    end else if (ctrlA && !ctrlPrev) begin
      cycCnt <= 20'h00000;
      stepsLeft <= onCode;
      if (onCode == 4'h0) begin
        seqState <= csr_pkg::CSR_ON;
        stepdownARun <= 1'b1;
      end else begin
        seqState <= csr_pkg::CSR_TO_ON;
      end
    end else if (!ctrlA && ctrlPrev) begin
      cycCnt <= 20'h00000;
      stepsLeft <= offCode;
      if (offCode == 4'h0) begin
        seqState <= csr_pkg::CSR_OFF;
        stepdownARun <= 1'b0;
      end else begin
        seqState <= csr_pkg::CSR_TO_OFF;
      end
    end else if (seqState == csr_pkg::CSR_TO_ON || seqState == csr_pkg::CSR_TO_OFF) begin
      if (cycCnt == stepLen - 20'h00001) begin
        cycCnt <= 20'h00000;
        stepsLeft <= 4'(stepsLeft - 4'h1);
        if (stepsLeft == 4'h1) begin
          stepdownARun <= (seqState == csr_pkg::CSR_TO_ON);
          seqState <= (seqState == csr_pkg::CSR_TO_ON) ? csr_pkg::CSR_ON : csr_pkg::CSR_OFF;
        end
      end else begin
        cycCnt <= 20'(cycCnt + 20'h00001);
      end
    end
  end

  property p_limit_follows;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> stepdownBPeakLimit == $past(limitSlew[csr_pkg::LIM_HI:csr_pkg::LIM_LO]);
  endproperty
  a_limit_follows: assert property (p_limit_follows) else $error("limit output stale");

  property p_run_gate;
    @(posedge clk) disable iff (!rst_n)
      !stepupCtl[csr_pkg::SU_EN] |=> !stepupRun;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("stepup ran with enable bit clear");

  property p_discharge;
    @(posedge clk) disable iff (!rst_n)
      stepupRun |-> !stepupDischargeOn;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge while running");

  property p_pin_gate;
    @(posedge clk) disable iff (!rst_n)
      (stepupCtl[csr_pkg::SU_SRC_HI:csr_pkg::SU_SRC_LO] == csr_pkg::SRC_PIN_1 && !enablePinFirst) |=> !stepupRun;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin gate ignored");

  sequence s_rise_zero;
    ctrlA && !ctrlPrev && onCode == 4'h0;
  endsequence
  property p_on_zero;
    @(posedge clk) disable iff (!rst_n)
      s_rise_zero |=> stepdownARun;
  endproperty
  a_on_zero: assert property (p_on_zero) else $error("zero on delay not immediate");

  sequence s_fall_nonzero;
    !ctrlA && ctrlPrev && offCode != 4'h0 && stepdownARun;
  endsequence
  property p_off_hold;
    @(posedge clk) disable iff (!rst_n)
      s_fall_nonzero |=> stepdownARun && seqState == csr_pkg::CSR_TO_OFF;
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("off delay skipped");

  property p_cnt_bound;
    @(posedge clk) disable iff (!rst_n)
      cycCnt < stepLen;
  endproperty
  a_cnt_bound: assert property (p_cnt_bound) else $error("step counter overran");

  property p_vcode_lo;
    @(posedge clk) disable iff (!rst_n)
      vcodeA == csr_pkg::VCODE_10MV_LO |=> stepdownAMv == csr_pkg::MV_BASE_10;
  endproperty
  a_vcode_lo: assert property (p_vcode_lo) else $error("voltage map wrong");
endmodule : converter_setting_regs
`default_nettype wire

// ==== src/csr_pkg.sv ====
// constants for the converter setting register slice
// assumes a byte-wide register port with 4-bit register index
package csr_pkg;
  localparam logic [3:0] ADDR_LIMIT_SLEW = 4'h5;
  localparam logic [3:0] ADDR_VCODE_A    = 4'h6;
  localparam logic [3:0] ADDR_VCODE_B    = 4'h7;
  localparam logic [3:0] ADDR_STEPUP     = 4'h8;
  localparam logic [3:0] ADDR_SEQ_A      = 4'h9;
  localparam logic [7:0] RST_LIMIT_SLEW  = 8'h1a;
  localparam logic [7:0] RST_VCODE       = 8'h00;
  localparam logic [7:0] RST_STEPUP      = 8'h08;
  localparam logic [7:0] RST_SEQ         = 8'h00;
  localparam int LIM_HI = 5;
  localparam int LIM_LO = 3;
  localparam int RAMP_HI = 2;
  localparam int RAMP_LO = 0;
  localparam int SU_V_HI = 7;
  localparam int SU_V_LO = 6;
  localparam int SU_DIS = 3;
  localparam int SU_SRC_HI = 2;
  localparam int SU_SRC_LO = 1;
  localparam int SU_EN = 0;
  localparam int OFF_HI = 7;
  localparam int OFF_LO = 4;
  localparam int ON_HI = 3;
  localparam int ON_LO = 0;
  localparam logic [2:0] LIM_RESERVED  = 3'h7;
  localparam logic [2:0] RAMP_RSV_MAX  = 3'h1;
  localparam logic [7:0] VCODE_RSV_MAX = 8'h13;
  localparam logic [7:0] VCODE_10MV_LO = 8'h14;
  localparam logic [7:0] VCODE_5MV_LO  = 8'h18;
  localparam logic [7:0] VCODE_20MV_LO = 8'h9e;
  // voltage outputs are in mV
  localparam logic [11:0] MV_BASE_10 = 12'h2bc;  // 700
  localparam logic [11:0] MV_BASE_5  = 12'h2df;  // 735
  localparam logic [11:0] MV_BASE_20 = 12'h58c;  // 1420
  localparam logic [11:0] MV_STEP_10 = 12'h00a;
  localparam logic [11:0] MV_STEP_5  = 12'h005;
  localparam logic [11:0] MV_STEP_20 = 12'h014;
  localparam int CLK_HZ = 25000000;
  localparam int DELAY_STEP_US = 500;
  localparam int STEP_CYCLES = CLK_HZ / 1000000 * DELAY_STEP_US;
  localparam logic [1:0] SRC_BIT_ONLY = 2'h0;
  localparam logic [1:0] SRC_PIN_1 = 2'h1;
  localparam logic [1:0] SRC_PIN_2 = 2'h2;
  typedef enum logic [1:0] {
    CSR_OFF    = 2'b00,
    CSR_TO_ON  = 2'b01,
    CSR_ON     = 2'b10,
    CSR_TO_OFF = 2'b11
  } csr_seq_e;
endpackage : csr_pkg

// ==== tb/csr_host_model.sv ====
// host side of the register port: byte writes and reads
// assumes the bench calls its tasks; drives on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module csr_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] regRdata,
  output logic            regWrite,
  output logic      [3:0] regAddr,
  output logic      [7:0] regWdata
);
  initial begin
    regWrite = 1'b0;
    regAddr  = 4'h0;
    regWdata = 8'h00;
  end
  // strobe stays up past the edge; next rd or idle lowers it
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr  = a;
    regWdata = d;
    @(posedge clk);
  endtask : wr
  // released data flips so a stale byte never looks valid
  task automatic idle();
    @(negedge clk);
    regWrite = 1'b0;
    regWdata = ~regWdata;
  endtask : idle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b0;
    regAddr  = a;
    @(posedge clk);
    d = regRdata;
  endtask : rd
endmodule : csr_host_model
`default_nettype wire

// ==== tb/tb_converter_setting_regs.sv ====
// self-checking bench for the converter setting register slice
// assumes csr_host_model on the register port; delay step cut to 4 cycles
`timescale 1ns/10ps
`default_nettype none
module tb_converter_setting_regs;
  // {sel, addr, data, expected}
  localparam logic [27:0] ROWS [21] = '{28'h05005dc, 28'h0528fa0, 28'h051abb8, 28'h1530006,
    28'h2502004, 28'h2507080, 28'h2501000, 28'h2505020, 28'h36142bc, 28'h36172da, 28'h36182df,
    28'h369d578, 28'h369e58c, 28'h36ffd20, 28'h47182df, 28'h47ffd20, 28'h47152c6, 28'h5808000,
    28'h5848001, 28'h5888002, 28'h58c8003};
  localparam logic [7:0] RST [6] = '{8'h1a, 8'h00, 8'h00, 8'h08, 8'h00, 8'h00};
  logic        clk;
  logic        rst_n;
  logic        regWrite;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata;
  logic [7:0]  regRdata;
  logic        otpLoad;
  logic [7:0]  otpv [5];
  logic [2:0]  pins;
  logic        scale;
  logic        ctrlBit;
  logic [1:0]  src;
  logic [2:0]  peak;
  logic [12:0] limMa;
  logic [12:0] suMv;
  logic [2:0]  ramp;
  logic [7:0]  rampCode;
  logic [11:0] mvA;
  logic [11:0] mvB;
  logic [1:0]  suCode;
  logic        suDis;
  logic        suFpwm;
  logic        suRun;
  logic        aRun;
  logic [7:0]  rb;
  int          err_total;
  int          checks_done;
  converter_setting_regs #(.STEP_CYC(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
    .regRdata(regRdata), .otpLoad(otpLoad), .otpLimitSlew(otpv[0]), .otpVcodeA(otpv[1]),
    .otpVcodeB(otpv[2]), .otpStepup(otpv[3]), .otpSeqA(otpv[4]), .enablePinFirst(pins[0]),
    .enablePinSecond(pins[1]), .enablePinThird(pins[2]), .delayScale(scale),
    .stepdownACtrlBit(ctrlBit), .stepdownASrc(src), .stepdownBPeakLimit(peak),
    .stepdownBLimitMa(limMa), .stepdownBRampRate(ramp), .stepdownBRampCode(rampCode),
    .stepdownAMv(mvA), .stepdownBMv(mvB), .stepupVoltageCode(suCode), .stepupMv(suMv),
    .stepupDischargeOn(suDis), .stepupForcedFixedFreq(suFpwm), .stepupRun(suRun),
    .stepdownARun(aRun));
  csr_host_model u_host (.clk(clk), .regRdata(regRdata), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata));
  always #20 clk = ~clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [11:0] pick(input logic [3:0] s);
    case (s)
      4'h0: pick = limMa[11:0];
      4'h1: pick = 12'(peak);
      4'h2: pick = 12'(rampCode);
      4'h3: pick = mvA;
      4'h4: pick = mvB;
      default: pick = 12'(suCode);
    endcase
  endfunction : pick
  task automatic rstChk();
    for (int i = 0; i < 6; i++) begin
      u_host.rd(4'(i + 5), rb);
      chk(12'(rb), 12'(RST[i]));
    end
    @(negedge clk);
    chk(12'(suDis), 12'h001);
    chk(limMa[11:0], 12'hbb8);
    chk(12'(rampCode), 12'h004);
  endtask : rstChk
  // bounded wait for the sequenced output; counts falling edges
  task automatic waitRun(input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while (aRun !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk(12'(n >= lo && n <= hi), 12'h001);
    if (n >= 400) tally_and_finish();
  endtask : waitRun
  // control is bit AND first pin, so the pin is the toggling source
  task automatic seqCase(input logic [3:0] on, input logic [3:0] off, input logic sc);
    int len;
    len = sc ? 8 : 4;
    u_host.wr(4'h9, {off, on});
    u_host.idle();
    scale = sc;
    @(negedge clk);
    pins[0] = 1'b1;
    waitRun(1'b1, on * len, on * len + 3);
    @(negedge clk);
    pins[0] = 1'b0;
    waitRun(1'b0, off * len, off * len + 3);
  endtask : seqCase
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    otpLoad = 1'b0;
    otpv = '{8'h2b, 8'h20, 8'h30, 8'h49, 8'h21};
    pins = 3'h0;
    scale = 1'b0;
    ctrlBit = 1'b1;
    src = 2'h1;
    err_total = 0;
    checks_done = 0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    rstChk();
    // write in the load cycle must lose
    fork
      begin
        u_host.wr(4'h6, 8'h40);
        u_host.idle();
      end
      begin
        @(negedge clk);
        otpLoad = 1'b1;
        @(negedge clk);
        otpLoad = 1'b0;
      end
    join
    for (int i = 0; i < 5; i++) begin
      u_host.rd(4'(i + 5), rb);
      chk(12'(rb), 12'(otpv[i]));
    end
    foreach (ROWS[i]) begin
      u_host.wr(ROWS[i][23:20], ROWS[i][19:12]);
      u_host.rd(ROWS[i][23:20], rb);
      @(negedge clk);
      chk(12'(rb), 12'(ROWS[i][19:12]));
      chk(pick(ROWS[i][27:24]), ROWS[i][11:0]);
    end
    // last row leaves step-up code 3: 5200 mV
    chk(suMv[11:0], 12'h450);
    chk(12'(suMv[12]), 12'h001);
    u_host.wr(4'h5, 8'h08);
    u_host.wr(4'h5, 8'h13);
    u_host.idle();
    @(negedge clk);
    chk(12'(peak), 12'h002);
    chk(12'(ramp), 12'h003);
    // code 6 is 4500 mA, beyond 12 bits
    u_host.wr(4'h5, 8'h30);
    u_host.idle();
    @(negedge clk);
    chk(limMa[11:0], 12'h194);
    chk(12'(limMa[12]), 12'h001);
    for (int s = 0; s < 4; s++) begin
      for (int v = 0; v < 2; v++) begin
        pins = (s == 0) ? {3{v[0]}} : (v[0] ? 3'(1 << (s - 1)) : ~3'(1 << (s - 1)));
        u_host.wr(4'h8, 8'h09 | 8'(s << 1));
        u_host.idle();
        @(negedge clk);
        chk(12'(suRun), 12'(s == 0 || v[0]));
        chk(12'(suDis), 12'(!(s == 0 || v[0])));
      end
    end
    u_host.wr(4'h8, 8'h00);
    u_host.idle();
    @(negedge clk);
    chk(12'({suRun, suDis, suFpwm}), 12'h000);
    pins = 3'h0;
    repeat (70) @(negedge clk);
    chk(12'(aRun), 12'h000);
    seqCase(4'h3, 4'h2, 1'b0);
    seqCase(4'h2, 4'h5, 1'b1);
    seqCase(4'h0, 4'h0, 1'b0);
    seqCase(4'hf, 4'hf, 1'b1);
    rst_n = 1'b0;
    @(negedge clk);
    rst_n = 1'b1;
    rstChk();
    tally_and_finish();
  end
endmodule : tb_converter_setting_regs
`default_nettype wire
